// *** core/cbis_bus_seq.sv ***
// ****************************************************************
// Bus sequencer: memory, I/O and interrupt entry cycles
// ****************************************************************
module cbis_bus_seq (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // User side: one request per bus cycle
  input  wire logic                          opStart,
  input  wire cbis_pkg::cbis_op_t            opKind,
  input  wire logic [cbis_pkg::ADDR_W-1:0]   opAddr,
  input  wire logic [cbis_pkg::PORT_W-1:0]   ioPort,
  input  wire logic                          ioDataSel,
  input  wire logic [cbis_pkg::DATA_W-1:0]   wrData,
  input  wire logic                          instrEnd,
  input  wire logic                          inhibitClear,
  output logic                               opBusy,
  output logic                               opDone,
  output logic [cbis_pkg::DATA_W-1:0]        rdData,
  output logic                               irqTaken,
  output logic [cbis_pkg::ADDR_W-1:0]        irqTarget,
  output logic [cbis_pkg::ADDR_W-1:0]        instrAddr,
  output logic                               irq_inhibit,
  // Pins
  output logic [cbis_pkg::ADDR_W-1:0]        addrOut,
  output logic                               memSelect,
  output logic                               writeSel,
  output logic                               extended_io_select,
  output logic                               write_strobe,
  output logic                               op_request,
  input  wire logic                          op_acknowledge_n,
  output logic                               irq_acknowledge,
  input  wire logic                          irq_request_n,
  input  wire logic [cbis_pkg::DATA_W-1:0]   dataIn,
  output logic [cbis_pkg::DATA_W-1:0]        dataOut,
  output logic                               dataOe
);
  import cbis_pkg::*;

  cbis_state_t        state_q,   state_d;
  logic               busy_q,    busy_d;
  logic [ADDR_W-1:0]  addr_q,    addr_d;
  logic               mem_q,     mem_d;
  logic               wr_q,      wr_d;
  logic               ext_q,     ext_d;
  logic               strobe_q,  strobe_d;
  logic               req_q,     req_d;
  logic               ack_q,     ack_d;
  logic [DATA_W-1:0]  dout_q,    dout_d;
  logic               doe_q,     doe_d;
  logic [DATA_W-1:0]  rd_q,      rd_d;
  logic               done_q,    done_d;
  logic               taken_q,   taken_d;
  logic [ADDR_W-1:0]  target_q,  target_d;
  logic [ADDR_W-1:0]  iar_q,     iar_d;
  logic               inh_q,     inh_d;
  logic [1:0]         phase;
  logic               lastPhase;
  logic               running;
  logic               ackLate;
  logic               irqGo;
  logic               startGo;
  logic               cycEnd;

  assign running = (state_q == CBIS_CYCLE) || (state_q == CBIS_VECTOR);
  assign ackLate = op_acknowledge_n;

  cbis_phase_ctr u_phase (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .run       (running),
    .hold      (ackLate),
    .phase     (phase),
    .lastPhase (lastPhase)
  );

  // ****************************************************************
  // Operation decoding
  // ****************************************************************
  function automatic logic isMemOp(input cbis_op_t op);
    return (op == CBIS_OP_MEM_RD) || (op == CBIS_OP_MEM_WR);
  endfunction

  function automatic logic isExtOp(input cbis_op_t op);
    return (op == CBIS_OP_EXT_RD) || (op == CBIS_OP_EXT_WR);
  endfunction

  function automatic logic isIoOp(input cbis_op_t op);
    return (op == CBIS_OP_IO_RD) || (op == CBIS_OP_IO_WR);
  endfunction

  // Sign-extended displacement from location zero
  function automatic logic [ADDR_W-1:0] relZero(input logic [DATA_W-1:0] v);
    return ZERO_LOC + {{(ADDR_W-DATA_W){v[DATA_W-1]}}, v}; // see R12
  endfunction

  // Interrupt wins over a new request at an instruction boundary
  assign irqGo   = (state_q == CBIS_IDLE) && instrEnd && !irq_request_n && !inh_q; // see R08, R15
  assign startGo = (state_q == CBIS_IDLE) && !irqGo && opStart;
  assign cycEnd  = running && lastPhase && !op_acknowledge_n; // see R13, R14, R19

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      CBIS_IDLE: begin
        if (irqGo) begin
          state_d = CBIS_VECTOR;
        end else if (startGo) begin
          state_d = CBIS_CYCLE;
        end
      end
      CBIS_CYCLE: begin
        if (cycEnd) begin
          state_d = CBIS_IDLE;
        end
      end
      CBIS_VECTOR: begin
        // One spare cycle lets the branch target settle before the next fetch
        if (cycEnd) begin
          state_d = CBIS_BRANCH;
        end
      end
      CBIS_BRANCH: begin
        state_d = CBIS_IDLE;
      end
      default: begin
        state_d = CBIS_IDLE;
      end
    endcase
    busy_d = (state_d != CBIS_IDLE);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= CBIS_IDLE;
      busy_q  <= 1'h0;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
    end
  end

  // ****************************************************************
  // Address and control lines
  // ****************************************************************
  always_comb begin
    addr_d = addr_q;
    mem_d  = mem_q;
    wr_d   = wr_q;
    ext_d  = ext_q;
    dout_d = dout_q;
    doe_d  = doe_q;
    if (irqGo) begin
      // Vector fetch is a read from location zero
      addr_d = ZERO_LOC; // see R10
      mem_d  = 1'h0;
      wr_d   = 1'h0;
      ext_d  = 1'h0;
      doe_d  = 1'h0;
    end else if (startGo) begin
      wr_d   = cbisIsWrite(opKind);
      dout_d = wrData; // see R04
      doe_d  = cbisIsWrite(opKind);
      mem_d  = isMemOp(opKind);
      ext_d  = isExtOp(opKind);
      addr_d = opAddr;
      if (isExtOp(opKind)) begin
        addr_d = {{(ADDR_W-PORT_W){1'b0}}, ioPort}; // see R03
      end else if (isIoOp(opKind)) begin
        // Single-byte I/O: only the data/control select matters, see R01
        addr_d = {1'b0, ioDataSel, {(ADDR_W-2){1'b0}}}; // see R02
      end
    end else if (cycEnd) begin
      doe_d = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_q <= ADDR_RESET;
      mem_q  <= 1'h0;
      wr_q   <= 1'h0;
      ext_q  <= 1'h0;
      dout_q <= 8'h00;
      doe_q  <= 1'h0;
    end else begin
      addr_q <= addr_d;
      mem_q  <= mem_d;
      wr_q   <= wr_d;
      ext_q  <= ext_d;
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end

  // ****************************************************************
  // Request, acknowledge and write strobe
  // ****************************************************************
  always_comb begin
    req_d    = req_q;
    ack_d    = ack_q;
    strobe_d = 1'h1; // see R17
    if (irqGo) begin
      req_d = 1'h1; // see R10
      ack_d = 1'h1; // see R16
    end else if (startGo) begin
      req_d    = 1'h1; // see R06, R19
      // Low ahead of the pulse so that the whole pulse sits inside the request
      strobe_d = !cbisIsWrite(opKind);
    end else if (cycEnd) begin
      req_d = 1'h0;
      ack_d = 1'h0;
    end else if (running && wr_q) begin
      // High for the middle clock only; low again while waiting, see R07
      strobe_d = (phase == 2'h0); // see R17
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      req_q    <= 1'h0;
      ack_q    <= 1'h0;
      strobe_q <= 1'h1;
    end else begin
      req_q    <= req_d;
      ack_q    <= ack_d;
      strobe_q <= strobe_d;
    end
  end

  // ****************************************************************
  // Read data, interrupt target and instruction address
  // ****************************************************************
  always_comb begin
    rd_d     = rd_q;
    done_d   = 1'h0;
    taken_d  = 1'h0;
    target_d = target_q;
    iar_d    = iar_q;
    if (startGo && isMemOp(opKind)) begin
      iar_d = opAddr;
    end
    if (cycEnd) begin
      done_d = 1'h1;
      rd_d   = dataIn;
      if (state_q == CBIS_VECTOR) begin
        // Vector byte from the interrupting device, see R11
        target_d = relZero(dataIn);
        iar_d    = relZero(dataIn); // see R12
        taken_d  = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_q     <= 8'h00;
      done_q   <= 1'h0;
      taken_q  <= 1'h0;
      target_q <= ZERO_LOC;
      iar_q    <= ADDR_RESET; // see R18
    end else begin
      rd_q     <= rd_d;
      done_q   <= done_d;
      taken_q  <= taken_d;
      target_q <= target_d;
      iar_q    <= iar_d;
    end
  end

  // ****************************************************************
  // Interrupt inhibit bit
  // ****************************************************************
  always_comb begin
    inh_d = inh_q;
    if (inhibitClear) begin
      inh_d = 1'h0;
    end
    // Entry is looked at last so that it wins over a clear in the same cycle
    if (irqGo) begin
      inh_d = 1'h1; // see R09
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inh_q <= 1'h0; // see R18
    end else begin
      inh_q <= inh_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign opBusy             = busy_q;
  assign opDone             = done_q;
  assign rdData             = rd_q;
  assign irqTaken           = taken_q;
  assign irqTarget          = target_q;
  assign instrAddr          = iar_q;
  assign irq_inhibit        = inh_q;
  assign addrOut            = addr_q;
  assign memSelect          = mem_q;
  assign writeSel           = wr_q;
  assign extended_io_select = ext_q;
  assign write_strobe       = strobe_q;
  assign op_request         = req_q;
  assign irq_acknowledge    = ack_q;
  assign dataOut            = dout_q;
  assign dataOe             = doe_q;
endmodule // cbis_bus_seq

// *** core/cbis_pkg.sv ***
// What this block does
// R01 - Non-extended I/O is single-byte, any register
// R02 - Select line marks data versus control transfer
// R03 - Extended I/O port address on low lines
// R04 - Extended I/O moves data to any register
// R05 - Outside logic may decode unused memory addresses
// R06 - Memory transfers use request/acknowledge handshake
// R07 - Write strobe usable as memory chip enable
// R08 - One interrupt level, vector from device
// R09 - Finish instruction, then set inhibit bit
// R10 - Branch relative zero with acknowledge and request
// R11 - Interrupting device drives vector on acknowledge
// R12 - Vector used as displacement from zero
// R13 - Processor cycle is three clock periods
// R14 - Late acknowledge stretches cycle by whole clocks
// R15 - Sample request at instruction end, uninhibited
// R16 - Raise acknowledge when ready for vector
// R17 - Strobe pulses on writes, high on reads
// R18 - Reset clears address and inhibit bit
// R19 - Hold bus valid until acknowledge ends transfer
package cbis_pkg;

  // ****************************************************************
  // Widths and positions
  // ****************************************************************
  localparam int          ADDR_W       = 15;
  localparam int          DATA_W       = 8;
  localparam int          PORT_W       = 8;
  localparam int          PSU_INHIBIT  = 6;
  localparam logic [14:0] ADDR_RESET   = 15'h0000;
  localparam logic [7:0]  PSU_RESET    = 8'h00;
  localparam logic [14:0] ZERO_LOC     = 15'h0000;
  localparam logic [1:0]  PHASE_RESET  = 2'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PER_CYC  = 3;
  localparam logic [1:0]  PHASE_LAST   = 2'h2;

  // ****************************************************************
  // Operation commands from the sequencer user
  // ****************************************************************
  typedef enum logic [2:0] {
    CBIS_OP_MEM_RD  = 3'h0,
    CBIS_OP_MEM_WR  = 3'h1,
    CBIS_OP_IO_RD   = 3'h2,
    CBIS_OP_IO_WR   = 3'h3,
    CBIS_OP_EXT_RD  = 3'h4,
    CBIS_OP_EXT_WR  = 3'h5
  } cbis_op_t;

  typedef enum logic [4:0] {
    CBIS_IDLE   = 5'b00001,
    CBIS_CYCLE  = 5'b00010,
    CBIS_WAIT   = 5'b00100,
    CBIS_VECTOR = 5'b01000,
    CBIS_BRANCH = 5'b10000
  } cbis_state_t;

  function automatic logic cbisIsWrite(input cbis_op_t op);
    return op[0];
  endfunction

endpackage : cbis_pkg

// *** core/cbis_phase_ctr.sv ***
// ****************************************************************
// Three-clock processor cycle timer
// ****************************************************************
module cbis_phase_ctr (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic       hold,
  output logic [1:0]      phase,
  output logic            lastPhase
);
  import cbis_pkg::*;

  logic [1:0] phase_q;
  logic [1:0] phase_d;

  always_comb begin
    phase_d = phase_q;
    if (!run) begin
      phase_d = 2'h0;
    end else if (phase_q != PHASE_LAST) begin
      phase_d = phase_q + 2'h1; // see R13
    end else if (!hold) begin
      phase_d = 2'h0;
    end
    // Holding at the last phase stretches in whole clocks, see R14
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_q <= PHASE_RESET;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase     = phase_q;
  assign lastPhase = (phase_q == PHASE_LAST);
endmodule // cbis_phase_ctr

// *** bench/cbis_chk.sv ***
// ******
// Bus sequencer checker
// ******
module cbis_chk (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        opStart,
  input wire logic        instrEnd,
  input wire logic        opBusy,
  input wire logic        opDone,
  input wire logic        irq_inhibit,
  input wire logic [14:0] addrOut,
  input wire logic        writeSel,
  input wire logic        write_strobe,
  input wire logic        op_request,
  input wire logic        op_acknowledge_n,
  input wire logic        irq_acknowledge,
  input wire logic        irq_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  req_start_a: assert property (!opBusy && opStart |=> op_request)
    else $error("no request after start");
  three_cyc_a: assert property ($rose(op_request) |-> op_request[*3])
    else $error("cycle shorter than three clocks");
  hold_req_a: assert property (op_request && op_acknowledge_n |=>
    op_request && $stable(addrOut) && $stable(writeSel))
    else $error("transfer dropped before acknowledge");
  end_ack_a: assert property (op_request[*3] ##0 !op_acknowledge_n |=>
    !op_request && (opDone || $past(irq_acknowledge)))
    else $error("acknowledge did not end transfer");
  strobe_read_a: assert property (op_request && !writeSel |-> write_strobe)
    else $error("strobe low in read");
  strobe_pulse_a: assert property ($rose(op_request) && writeSel |->
    !write_strobe ##1 write_strobe ##1 !write_strobe)
    else $error("write strobe pulse wrong");
  irq_entry_a: assert property (!opBusy && instrEnd && !irq_request_n &&
    !irq_inhibit |=> irq_acknowledge && op_request && irq_inhibit && addrOut == 15'h0000)
    else $error("interrupt entry wrong");
  irq_block_a: assert property (!opBusy && !opStart && (irq_inhibit || !instrEnd)
    |=> !op_request)
    else $error("interrupt taken while blocked");
endmodule // cbis_chk
bind cbis_bus_seq cbis_chk cbis_chk_inst (.*);

// *** bench/cbis_partner.sv ***
// ******
// Memory, I/O and interrupting device model
// ******
module cbis_partner (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [1:0]  lat,
  input wire logic        raise,
  input wire logic [7:0]  vec,
  input wire logic        op_request,
  input wire logic        writeSel,
  input wire logic        irq_acknowledge,
  input wire logic [14:0] addrOut,
  input wire logic [7:0]  dataOut,
  output logic            op_acknowledge_n,
  output logic            irq_request_n,
  output logic [7:0]      dataIn,
  output logic [7:0]      wrSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 3'h0;
      op_acknowledge_n <= 1'h1;
      irq_request_n <= 1'h1;
      dataIn <= 8'h00;
      wrSeen <= 8'h00;
    end else begin
      cnt <= op_request ? cnt + 3'h1 : 3'h0;
      // One clock only, so a stale low never ends the next transfer
      op_acknowledge_n <= !(op_request && op_acknowledge_n && cnt >= 3'h1 + 3'(lat));
      irq_request_n <= !((!irq_request_n || raise) && !irq_acknowledge);
      if (irq_acknowledge)
        dataIn <= vec;
      else if (op_request && !writeSel)
        dataIn <= addrOut[7:0] ^ 8'h5A;
      else
        dataIn <= ~dataIn;
      if (op_request && writeSel && !op_acknowledge_n)
        wrSeen <= dataOut;
    end
  end
endmodule // cbis_partner

// *** bench/tb.sv ***
// ******
// Bus sequencer testbench
// ******
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbis_pkg::*;
  logic        clk_sys = 1'h0, nrst = 1'h0, opStart = 1'h0, ioDataSel = 1'h0;
  logic        instrEnd = 1'h0, inhibitClear = 1'h0, raise = 1'h0;
  logic [1:0]  lat = 2'h0;
  cbis_op_t    opKind = CBIS_OP_MEM_RD;
  logic [14:0] opAddr = 15'h0000, irqTarget, instrAddr, addrOut;
  logic [7:0]  ioPort = 8'h00, wrData = 8'h00, vec = 8'h00, rdData, dataIn, dataOut, wrSeen;
  logic        opBusy, opDone, irqTaken, irq_inhibit, memSelect, writeSel, extended_io_select;
  logic        write_strobe, op_request, op_acknowledge_n, irq_acknowledge, irq_request_n, dataOe;
  int          fails = 0, samples_checked = 0, cycles = 0, n;
  cbis_bus_seq cbis_bus_seq_inst (.*);
  cbis_partner cbis_partner_inst (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    samples_checked++;
    if (exp !== got) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitFor(ref logic sig);
    n = 0;
    while (sig !== 1'h1 && n < 30) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic doOp(input cbis_op_t k, input logic [7:0] v, input logic [1:0] l);
    @(posedge clk_sys);
    opKind <= k;
    opAddr <= {7'h35, v};
    ioPort <= v;
    ioDataSel <= v[0];
    wrData <= ~v;
    lat <= l;
    opStart <= 1'h1;
    @(posedge clk_sys);
    opStart <= 1'h0;
    #1;
    chk("ctl", 15'({k < 3'h2, k[0], k[0], k > 3'h3, 1'h1}),
      15'({memSelect, writeSel, dataOe, extended_io_select, op_request}));
    if (k > 3'h3)
      chk("port", 15'(v), 15'(addrOut[7:0]));
    else if (k > 3'h1)
      chk("dcSel", 15'(v[0]), 15'(addrOut[13]));
    else
      chk("addr", {7'h35, v}, addrOut);
    waitFor(opDone);
    chk("cycles", 15'(3 + l), 15'(n));
    if (k[0])
      chk("wrData", {7'h00, ~v}, 15'(wrSeen));
    else
      chk("rdData", 15'(((k == CBIS_OP_IO_RD) ? 8'h00 : v) ^ 8'h5A), 15'(rdData));
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'h1;
    #1;
    chk("pc", 15'h0000, instrAddr);
    chk("idle", 15'h0001, 15'({irq_inhibit, write_strobe}));
    for (int i = 0; i < 6; i++)
      doOp(cbis_op_t'(i), 8'(8'h93 + 8'h21 * i), 2'h0);
    for (int i = 1; i < 4; i++)
      doOp(cbis_op_t'(i), 8'(8'h7F * i), 2'(i));
    @(posedge clk_sys);
    vec <= 8'hF0;
    raise <= 1'h1;
    repeat (4) @(posedge clk_sys);
    instrEnd <= 1'h1;
    #1;
    chk("noEnd", 15'h0000, 15'(op_request));
    waitFor(irqTaken);
    chk("target", 15'h7FF0, irqTarget);
    chk("pcIrq", 15'h7FF0, instrAddr);
    chk("inhibit", 15'h0001, 15'(irq_inhibit));
    doOp(CBIS_OP_MEM_RD, 8'h3C, 2'h0);
    @(posedge clk_sys);
    raise <= 1'h0;
    instrEnd <= 1'h0;
    inhibitClear <= 1'h1;
    @(posedge clk_sys);
    inhibitClear <= 1'h0;
    instrEnd <= 1'h1;
    #1;
    chk("clear", 15'h0000, 15'(irq_inhibit));
    @(posedge clk_sys);
    #1;
    chk("reEntry", 15'h0001, 15'(irq_acknowledge));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h0;
    @(posedge clk_sys);
    nrst <= 1'h1;
    #1;
    chk("pcRst", 15'h0000, instrAddr);
    chk("inhRst", 15'h0000, 15'(irq_inhibit));
    finish_test();
  end
endmodule // tb
